// *** rtl/sync_serial_pkg.sv ***
package sync_serial_pkg;

  // ----------------------------------------------------------------
  // Clock and bit timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int ST_PERIOD_NS   = 320;
  localparam int ST_DIV_DEFAULT = ST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PHASE_CNT_W    = 8;
  localparam int SYNC_W         = 5;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE  = 4'h8;
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST   = 8'h00;

  // Status and mask bit positions
  localparam int EV_MOD_FAULT   = 0;
  localparam int EV_DEMOD_FAULT = 1;
  localparam int EV_RR_LOST     = 2;
  localparam int EV_CFG_CHANGE  = 3;
  localparam int EV_W           = 4;

  // Live state bit positions
  localparam int ST_DM       = 0;
  localparam int ST_RR       = 1;
  localparam int ST_CTS      = 2;
  localparam int ST_LOOP     = 3;
  localparam int ST_USE_FALL = 4;
  localparam int ST_MF_PIN   = 5;
  localparam int ST_DF_PIN   = 6;

  // Synchroniser lanes
  localparam int LN_SD  = 0;
  localparam int LN_TT  = 1;
  localparam int LN_RTS = 2;
  localparam int LN_MF  = 3;
  localparam int LN_DF  = 4;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_RX_SAT   = 2'h2;
  localparam logic [1:0] PH_AUTO      = 2'h0;
  localparam logic [1:0] PH_NORMAL    = 2'h1;
  localparam logic [1:0] PH_INVERT    = 2'h2;

  typedef enum logic [1:0] {
    AL_WAIT = 2'b01,
    AL_RUN  = 2'b10
  } align_state_t;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import sync_serial_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] stab;
  logic [W-1:0] prev;

  initial begin
    if (W < 1) $error("pin_sync needs at least one lane");
  end

  // Two-flop synchroniser, then a history flop for edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= '0;
      stab <= '0;
      prev <= '0;
    end else begin
      meta <= pin;
      stab <= meta;
      prev <= stab;
    end
  end

  // Edges come from the settled stage only
  assign level = stab;
  assign rise  = stab & ~prev;
  assign fall  = ~stab & prev;

endmodule
`default_nettype wire

// *** rtl/tx_phase_align.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_phase_align
  import sync_serial_pkg::*;
#(
  parameter int CNT_W = PHASE_CNT_W
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       resync,
  input  wire logic       clk_rise,
  input  wire logic       clk_fall,
  input  wire logic       sd,
  input  wire logic [1:0] phase_mode,
  output logic            tx_bit,
  output logic            tx_valid,
  output logic            use_fall
);

  align_state_t     state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] period, next_period;
  logic [CNT_W-1:0] pos, next_pos;
  logic             sd_q, next_sd_q;
  logic             next_bit, next_valid, next_use_fall;

  initial begin
    if (CNT_W < 3) $error("tx_phase_align counter too narrow");
  end

  // True when the data edge sits near the clock rising edge
  function automatic logic near_rise(input logic [CNT_W-1:0] p,
                                     input logic [CNT_W-1:0] per);
    logic [CNT_W-1:0] q;
    q = per >> 2;
    near_rise = (p < q) || (p >= per - q);
  endfunction

  // Measure bit period and data edge position, pick the sampling edge
  always_comb begin
    next_state    = state;
    next_cnt      = (&cnt) ? cnt : cnt + 1'b1;
    next_period   = period;
    next_pos      = pos;
    next_sd_q     = sd;
    next_bit      = tx_bit;
    next_valid    = 1'b0;
    next_use_fall = use_fall;
    if (clk_rise) begin
      next_cnt    = '0;
      next_period = (&cnt) ? cnt : cnt + 1'b1;
    end
    if (sd != sd_q) begin
      next_pos = cnt;
    end
    unique case (phase_mode)
      PH_NORMAL: next_use_fall = 1'b0;
      PH_INVERT: next_use_fall = 1'b1;
      default:   next_use_fall = near_rise(pos, period);
    endcase
    unique case (state)
      AL_WAIT: begin
        if (clk_rise) begin
          next_state = AL_RUN;
        end
      end
      AL_RUN: begin
        if (use_fall ? clk_fall : clk_rise) begin
          next_bit   = sd;
          next_valid = 1'b1;
        end
      end
    endcase
    if (resync) begin
      next_state  = AL_WAIT;
      next_cnt    = '0;
      next_period = '0;
      next_pos    = '0;
      next_valid  = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state    <= AL_WAIT;
      cnt      <= '0;
      period   <= '0;
      pos      <= '0;
      sd_q     <= 1'b0;
      tx_bit   <= 1'b0;
      tx_valid <= 1'b0;
      use_fall <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      period   <= next_period;
      pos      <= next_pos;
      sd_q     <= next_sd_q;
      tx_bit   <= next_bit;
      tx_valid <= next_valid;
      use_fall <= next_use_fall;
    end
  end

endmodule
`default_nettype wire

// *** rtl/sync_serial_dce_port.sv ***
// Behaviour
// - Drive send clock at modem data rate
// - External mode samples data on terminal clock
// - Move sampling edge away from data transitions
// - Phasing choices: auto, normal, inverted
// - Send clock output polarity selectable
// - Receive data and clock out; data polarity
// - Receive clock edge mid-bit per mode
// - Clear-to-send follows request-to-send directly
// - Data mode asserted when powered; polarity
// - Receiver ready needs carrier and lock; polarity
// - Loopback: send data and clock to receive
// - Loopback: receive path into modulator input
// - Loop timing replaces send clock with recovered
// - Separate buffered modulator and demodulator faults
`timescale 1ns/1ps
`default_nettype none
module sync_serial_dce_port
  import sync_serial_pkg::*;
#(
  parameter int ST_DIV = ST_DIV_DEFAULT
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq,
  input  wire logic [1:0]        tx_clk_src,
  input  wire logic [1:0]        tx_phase,
  input  wire logic              st_invert,
  input  wire logic              rt_invert,
  input  wire logic              rd_invert,
  input  wire logic              dm_invert,
  input  wire logic              rr_invert,
  input  wire logic              loopback,
  input  wire logic              handshake_strap,
  input  wire logic              sd_pin,
  input  wire logic              tt_pin,
  input  wire logic              rts_pin,
  output logic                   st_pin,
  output logic                   rd_pin,
  output logic                   rt_pin,
  output logic                   cts_pin,
  output logic                   dm_pin,
  output logic                   rr_pin,
  input  wire logic              mod_fault_pin_in,
  output logic                   mod_fault_pin_out,
  output logic                   mod_fault_pin_oe,
  input  wire logic              demod_fault_pin_in,
  output logic                   demod_fault_pin_out,
  output logic                   demod_fault_pin_oe,
  input  wire logic              demod_data,
  input  wire logic              demod_clk,
  input  wire logic              carrier_detect,
  input  wire logic              decoder_lock,
  input  wire logic              mod_fault,
  input  wire logic              demod_fault,
  output logic                   mod_data,
  output logic                   mod_strobe
);

  localparam int DIV_W  = $clog2(ST_DIV + 1);
  localparam int CFG_W  = 13;
  localparam int HALF_I = ST_DIV / 2;
  localparam int LAST_I = ST_DIV - 1;
  localparam logic [DIV_W-1:0] HALF = HALF_I[DIV_W-1:0];
  localparam logic [DIV_W-1:0] LAST = LAST_I[DIV_W-1:0];

  initial begin
    if (ST_DIV < 2 || (ST_DIV % 2) != 0) begin
      $error("ST_DIV must be even and at least 2");
    end
  end

  // Apply a selectable output polarity
  function automatic logic polar(input logic v, input logic inv);
    polar = v ^ inv;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_lvl;
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_fall;

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     ({demod_fault_pin_in, mod_fault_pin_in, rts_pin, tt_pin, sd_pin}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // ----------------------------------------------------------------
  // Configuration watch
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_now;
  logic [CFG_W-1:0] cfg_q, next_cfg_q;
  logic             resync, next_resync;

  assign cfg_now = {tx_clk_src, tx_phase, st_invert, rt_invert, rd_invert,
                    dm_invert, rr_invert, loopback, handshake_strap, 2'b00};

  // Any change of the settings restarts the transmit path
  always_comb begin
    next_cfg_q  = cfg_now;
    next_resync = (cfg_now != cfg_q);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q  <= '0;
      resync <= 1'b1;
    end else begin
      cfg_q  <= next_cfg_q;
      resync <= next_resync;
    end
  end

  // ----------------------------------------------------------------
  // Send clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic             st_int, next_st_int;
  logic             st_rise_t, st_fall_t;

  // Enable pulses at the data rate edges
  assign st_rise_t = (div_cnt == LAST);
  assign st_fall_t = (div_cnt == HALF - 1'b1);

  always_comb begin
    next_div_cnt = st_rise_t ? '0 : div_cnt + 1'b1;
    next_st_int  = st_int;
    if (st_rise_t) begin
      next_st_int = 1'b1;
    end else if (st_fall_t) begin
      next_st_int = 1'b0;
    end
    if (resync) begin
      next_div_cnt = '0;
      next_st_int  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= '0;
      st_int  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      st_int  <= next_st_int;
    end
  end

  // ----------------------------------------------------------------
  // Recovered clock edges
  // ----------------------------------------------------------------
  logic rxc_q, next_rxc_q;
  logic rx_rise, rx_fall;

  assign rx_rise = demod_clk & ~rxc_q;
  assign rx_fall = ~demod_clk & rxc_q;

  always_comb begin
    next_rxc_q = demod_clk;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxc_q <= 1'b0;
    end else begin
      rxc_q <= next_rxc_q;
    end
  end

  // ----------------------------------------------------------------
  // Transmit clock selection and phase alignment
  // ----------------------------------------------------------------
  logic sel_rise, sel_fall, sel_lvl;
  logic tx_bit, tx_valid, use_fall;

  // Pick the edges that clock send data in
  always_comb begin
    unique case (tx_clk_src)
      SRC_EXTERNAL: begin
        sel_rise = pin_rise[LN_TT];
        sel_fall = pin_fall[LN_TT];
        sel_lvl  = pin_lvl[LN_TT];
      end
      SRC_RX_SAT: begin
        sel_rise = rx_rise;
        sel_fall = rx_fall;
        sel_lvl  = rxc_q;
      end
      default: begin
        sel_rise = st_rise_t;
        sel_fall = st_fall_t;
        sel_lvl  = st_int;
      end
    endcase
  end

  tx_phase_align #(
    .CNT_W (PHASE_CNT_W)
  ) u_align (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .resync     (resync),
    .clk_rise   (sel_rise),
    .clk_fall   (sel_fall),
    .sd         (pin_lvl[LN_SD]),
    .phase_mode (tx_phase),
    .tx_bit     (tx_bit),
    .tx_valid   (tx_valid),
    .use_fall   (use_fall)
  );

  // ----------------------------------------------------------------
  // Pin and modulator outputs
  // ----------------------------------------------------------------
  logic st_src;
  logic next_st, next_rd, next_rt, next_cts, next_dm, next_rr;
  logic next_mdata, next_mstb, next_mf_oe, next_df_oe;
  logic rr_raw;

  assign st_src = (tx_clk_src == SRC_RX_SAT) ? rxc_q : st_int;
  assign rr_raw = carrier_detect & decoder_lock;

  // Route data, clocks and status toward the terminal and modulator
  always_comb begin
    next_st  = polar(st_src, st_invert);
    next_rd  = polar(demod_data, rd_invert);
    next_rt  = polar(demod_clk, rt_invert);
    next_cts = handshake_strap & pin_lvl[LN_RTS];
    next_dm  = polar(1'b1, dm_invert);
    next_rr  = polar(rr_raw, rr_invert);
    next_mdata = tx_bit;
    next_mstb  = tx_valid;
    if (loopback) begin
      next_rd    = polar(pin_lvl[LN_SD], rd_invert);
      next_rt    = polar(sel_lvl, rt_invert);
      next_mdata = demod_data;
      next_mstb  = rx_rise;
    end
    next_mf_oe = ~mod_fault;
    next_df_oe = ~demod_fault;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_pin             <= 1'b0;
      rd_pin             <= 1'b0;
      rt_pin             <= 1'b0;
      cts_pin            <= 1'b0;
      dm_pin             <= 1'b0;
      rr_pin             <= 1'b0;
      mod_data           <= 1'b0;
      mod_strobe         <= 1'b0;
      mod_fault_pin_oe   <= 1'b0;
      demod_fault_pin_oe <= 1'b0;
    end else begin
      st_pin             <= next_st;
      rd_pin             <= next_rd;
      rt_pin             <= next_rt;
      cts_pin            <= next_cts;
      dm_pin             <= next_dm;
      rr_pin             <= next_rr;
      mod_data           <= next_mdata;
      mod_strobe         <= next_mstb;
      mod_fault_pin_oe   <= next_mf_oe;
      demod_fault_pin_oe <= next_df_oe;
    end
  end

  // Open collector: only ever pulls low
  assign mod_fault_pin_out   = 1'b0;
  assign demod_fault_pin_out = 1'b0;

  // ----------------------------------------------------------------
  // Event status, mask and register port
  // ----------------------------------------------------------------
  logic [EV_W-1:0]   status, next_status;
  logic [EV_W-1:0]   mask, next_mask;
  logic [EV_W-1:0]   events;
  logic [DATA_W-1:0] next_rdata;
  logic              mf_q, df_q, rr_q;
  logic              next_mf_q, next_df_q, next_rr_q;
  logic [DATA_W-1:0] state_word;

  always_comb begin
    events                 = '0;
    events[EV_MOD_FAULT]   = mod_fault & ~mf_q;
    events[EV_DEMOD_FAULT] = demod_fault & ~df_q;
    events[EV_RR_LOST]     = ~rr_raw & rr_q;
    events[EV_CFG_CHANGE]  = resync;
  end

  always_comb begin
    state_word              = '0;
    state_word[ST_DM]       = dm_pin;
    state_word[ST_RR]       = rr_pin;
    state_word[ST_CTS]      = cts_pin;
    state_word[ST_LOOP]     = loopback;
    state_word[ST_USE_FALL] = use_fall;
    state_word[ST_MF_PIN]   = pin_lvl[LN_MF];
    state_word[ST_DF_PIN]   = pin_lvl[LN_DF];
  end

  // Write one to clear; a new event in the same cycle wins
  always_comb begin
    next_mf_q   = mod_fault;
    next_df_q   = demod_fault;
    next_rr_q   = rr_raw;
    next_status = status;
    next_mask   = mask;
    next_rdata  = '0;
    if (reg_wr && reg_addr == REG_STATUS) begin
      next_status = status & ~reg_wdata[EV_W-1:0];
    end
    if (reg_wr && reg_addr == REG_MASK) begin
      next_mask = reg_wdata[EV_W-1:0];
    end
    next_status = next_status | events;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: next_rdata = {{(DATA_W-EV_W){1'b0}}, status};
        REG_MASK:   next_rdata = {{(DATA_W-EV_W){1'b0}}, mask};
        REG_STATE:  next_rdata = state_word;
        default:    next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status    <= STATUS_RST[EV_W-1:0];
      mask      <= MASK_RST[EV_W-1:0];
      reg_rdata <= '0;
      mf_q      <= 1'b0;
      df_q      <= 1'b0;
      rr_q      <= 1'b0;
    end else begin
      status    <= next_status;
      mask      <= next_mask;
      reg_rdata <= next_rdata;
      mf_q      <= next_mf_q;
      df_q      <= next_df_q;
      rr_q      <= next_rr_q;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq = |(status & mask);

endmodule
`default_nettype wire

// *** tb/sync_serial_dce_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_dce_port_monitor
  import sync_serial_pkg::*;
#(
  parameter int ST_DIV = ST_DIV_DEFAULT
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [1:0] tx_clk_src,
  input wire logic [1:0] tx_phase,
  input wire logic       st_invert,
  input wire logic       rt_invert,
  input wire logic       rd_invert,
  input wire logic       dm_invert,
  input wire logic       rr_invert,
  input wire logic       loopback,
  input wire logic       handshake_strap,
  input wire logic       rts_pin,
  input wire logic       st_pin,
  input wire logic       rd_pin,
  input wire logic       cts_pin,
  input wire logic       dm_pin,
  input wire logic       rr_pin,
  input wire logic       mod_fault_pin_oe,
  input wire logic       demod_fault_pin_oe,
  input wire logic       demod_data,
  input wire logic       demod_clk,
  input wire logic       carrier_detect,
  input wire logic       decoder_lock,
  input wire logic       mod_fault,
  input wire logic       demod_fault,
  input wire logic       mod_data,
  input wire logic       mod_strobe,
  input wire logic       irq
);
  localparam int HALF = ST_DIV / 2;
  logic [1:0]  live;
  logic [3:0]  quiet;
  logic [10:0] cfg_q;
  wire logic [10:0] cfg = {tx_clk_src, tx_phase, st_invert, rt_invert, rd_invert,
    dm_invert, rr_invert, loopback, handshake_strap};

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Cycles since reset and since the last settings change
  always_ff @(posedge ref_clk) begin
    cfg_q <= cfg;
    if (rst) begin
      live  <= 2'd0;
      quiet <= 4'd0;
    end else begin
      live  <= (live == 2'd3) ? live : live + 2'd1;
      quiet <= (cfg_q != cfg) ? 4'd0 :
               (quiet == 4'd15) ? quiet : quiet + 4'd1;
    end
  end

  property p_st_period;
    @(posedge ref_clk) disable iff (rst || quiet == 4'd0)
    (quiet == 4'd15 && tx_clk_src == SRC_INTERNAL && !loopback && $rose(st_pin ^ st_invert))
      |-> ##HALF $fell(st_pin ^ st_invert) ##HALF $rose(st_pin ^ st_invert);
  endproperty
  a_st_period: assert property (p_st_period) else $error("send clock period wrong");

  property p_cts;
    (live == 2'd3 && $stable(rts_pin) && $stable(handshake_strap)) [*4]
      |-> cts_pin == (handshake_strap & rts_pin);
  endproperty
  a_cts: assert property (p_cts) else $error("cts does not follow rts");

  property p_dm;
    live == 2'd3 |-> dm_pin == !$past(dm_invert);
  endproperty
  a_dm: assert property (p_dm) else $error("data mode level wrong");

  property p_rr;
    live == 2'd3 |-> rr_pin == $past((carrier_detect & decoder_lock) ^ rr_invert);
  endproperty
  a_rr: assert property (p_rr) else $error("receiver ready level wrong");

  property p_rd;
    (live == 2'd3 && !$past(loopback)) |-> rd_pin == $past(demod_data ^ rd_invert);
  endproperty
  a_rd: assert property (p_rd) else $error("receive data wrong");

  property p_loop_mod;
    (live == 2'd3 && quiet > 4'd2 && $past(loopback) && $rose(demod_clk))
      |=> mod_strobe && mod_data == $past(demod_data);
  endproperty
  a_loop_mod: assert property (p_loop_mod) else $error("loopback to modulator wrong");

  property p_fault;
    live == 2'd3 |-> mod_fault_pin_oe == !$past(mod_fault)
      && demod_fault_pin_oe == !$past(demod_fault);
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin drive wrong");

  property p_strobe;
    mod_strobe |=> !mod_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("modulator strobe too long");

  // Main scenarios reached
  c_strobe: cover property (mod_strobe);
  c_irq: cover property ($rose(irq));
  c_loop: cover property (loopback && mod_strobe);
endmodule

bind sync_serial_dce_port sync_serial_dce_port_monitor #(.ST_DIV(ST_DIV)) u_mon (
  .ref_clk, .rst, .tx_clk_src, .st_invert, .rd_invert, .dm_invert, .rr_invert,
  .loopback, .handshake_strap, .rts_pin, .st_pin, .rd_pin, .cts_pin, .dm_pin, .rr_pin,
  .mod_fault_pin_oe, .demod_fault_pin_oe, .demod_data, .demod_clk, .carrier_detect,
  .decoder_lock, .mod_fault, .demod_fault, .mod_data, .mod_strobe, .irq, .tx_phase, .rt_invert);
`default_nettype wire

// *** tb/dte_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dte_model (
  input  wire logic st_pin,
  input  wire logic tt_mode,
  input  wire logic shift_rise,
  output logic      sd_pin,
  output logic      tt_pin
);
  logic [7:0] pat;
  wire logic  clk_sel;

  // Free-running terminal clock, phase unrelated to ref_clk
  initial begin
    pat    = 8'hB4;
    tt_pin = 1'b0;
    #13;
    forever #160 tt_pin = ~tt_pin;
  end

  // Launch data from our clock or the device send clock
  assign clk_sel = tt_mode ? tt_pin : st_pin;

  // Next bit on the launching edge, sampling edge left mid-bit
  always @(clk_sel) begin
    if (clk_sel === shift_rise) begin
      pat <= {pat[6:0], pat[7]};
    end
  end
  assign sd_pin = pat[7];
endmodule
`default_nettype wire

// *** tb/sync_serial_dce_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_dce_port_bench;
  import sync_serial_pkg::*;

  logic              ref_clk, rst, reg_wr, reg_rd, irq, tt_mode, shift_rise, st_prev;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, dpat;
  logic [1:0]        tx_clk_src, tx_phase, dcnt;
  logic              st_invert, rt_invert, rd_invert, dm_invert, rr_invert, loopback;
  logic              handshake_strap, sd_pin, tt_pin, rts_pin, st_pin, rd_pin, rt_pin;
  logic              cts_pin, dm_pin, rr_pin, mod_fault_pin_in, mod_fault_pin_out;
  logic              mod_fault_pin_oe, demod_fault_pin_in, demod_fault_pin_out;
  logic              demod_fault_pin_oe, demod_data, demod_clk, carrier_detect;
  logic              decoder_lock, mod_fault, demod_fault, mod_data, mod_strobe;
  int                fail_count, n_compared, i, n;

  sync_serial_dce_port #(.ST_DIV(8)) u_dut (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .tx_clk_src, .tx_phase, .st_invert, .rt_invert, .rd_invert, .dm_invert, .rr_invert,
    .loopback, .handshake_strap, .sd_pin, .tt_pin, .rts_pin, .st_pin, .rd_pin, .rt_pin,
    .cts_pin, .dm_pin, .rr_pin, .mod_fault_pin_in, .mod_fault_pin_out, .mod_fault_pin_oe,
    .demod_fault_pin_in, .demod_fault_pin_out, .demod_fault_pin_oe, .demod_data,
    .demod_clk, .carrier_detect, .decoder_lock, .mod_fault, .demod_fault, .mod_data,
    .mod_strobe);

  dte_model u_dte (.st_pin, .tt_mode, .shift_rise, .sd_pin, .tt_pin);

  // Open-collector fault lines with pull-up
  assign mod_fault_pin_in   = mod_fault_pin_oe ? mod_fault_pin_out : 1'b1;
  assign demod_fault_pin_in = demod_fault_pin_oe ? demod_fault_pin_out : 1'b1;

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Recovered clock, data changes on its falling edge
  always @(posedge ref_clk) begin
    dcnt <= dcnt + 2'd1;
    if (dcnt == 2'd3) begin
      demod_clk <= ~demod_clk;
      if (demod_clk) begin
        demod_data <= dpat[7];
        dpat       <= {dpat[6:0], dpat[7]};
      end
    end
  end

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check("reg_rdata", e & m, reg_rdata & m);
  endtask

  // Modulator bit must be the bit the terminal held just before the strobe
  task automatic run_tx(input logic [1:0] src, input logic [1:0] ph, input logic r);
    tx_clk_src <= src;
    tx_phase   <= ph;
    shift_rise <= r;
    tt_mode    <= (src == SRC_EXTERNAL);
    repeat (48) @(posedge ref_clk);
    #1;
    n = 0;
    for (i = 0; i < 600 && n < 10; i++) begin
      st_prev = sd_pin;
      @(posedge ref_clk);
      #1;
      if (mod_strobe === 1'b1) begin
        n++;
        check("mod_data", {7'h0, st_prev}, {7'h0, mod_data});
      end
    end
    if (n < 10) begin
      fail_count++;
      print_verdict();
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, st_invert, rt_invert, rd_invert, dm_invert, rr_invert, loopback} = '0;
    {rts_pin, handshake_strap, tt_mode, shift_rise} = 4'hC;
    {demod_clk, demod_data, carrier_detect, decoder_lock, mod_fault, demod_fault} = '0;
    {tx_clk_src, tx_phase, dcnt, reg_addr, reg_wdata} = '0;
    dpat = 8'h4D;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reg_read(REG_STATUS, 8'h08, 8'hFF);
    reg_read(REG_MASK, MASK_RST, 8'hFF);
    reg_write(4'hC, 8'hFF);
    reg_read(4'hC, 8'h00, 8'hFF);
    reg_write(REG_STATUS, 8'h08);
    reg_read(REG_STATUS, 8'h00, 8'hFF);
    reg_write(REG_MASK, 8'h0F);
    reg_read(REG_MASK, 8'h0F, 8'hFF);
    check("irq", 8'h00, {7'h0, irq});
    st_invert <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("irq", 8'h01, {7'h0, irq});
    reg_write(REG_MASK, 8'h00);
    #1;
    check("irq", 8'h00, {7'h0, irq});
    st_invert <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reg_write(REG_STATUS, 8'h0F);
    mod_fault <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_read(REG_STATUS, 8'h01, 8'h03);
    reg_read(REG_STATE, 8'h20, 8'h60);
    mod_fault   <= 1'b0;
    demod_fault <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_read(REG_STATUS, 8'h03, 8'h03);
    reg_read(REG_STATE, 8'h40, 8'h60);
    demod_fault <= 1'b0;
    {carrier_detect, decoder_lock} <= 2'h3;
    repeat (6) @(posedge ref_clk);
    reg_read(REG_STATE, 8'h07, 8'h0F);
    decoder_lock <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reg_read(REG_STATUS, 8'h04, 8'h04);
    handshake_strap <= 1'b0;
    {rt_invert, rd_invert, dm_invert, rr_invert} <= 4'hF;
    repeat (6) @(posedge ref_clk);
    reg_read(REG_STATE, 8'h02, 8'h07);
    check("rd_pin", {7'h0, ~demod_data}, {7'h0, rd_pin});
    {rt_invert, rd_invert, dm_invert, rr_invert} <= 4'h0;
    handshake_strap <= 1'b1;
    run_tx(SRC_INTERNAL, PH_AUTO, 1'b0);
    run_tx(SRC_EXTERNAL, PH_NORMAL, 1'b0);
    run_tx(SRC_EXTERNAL, PH_INVERT, 1'b1);
    run_tx(SRC_RX_SAT, PH_NORMAL, 1'b0);
    tx_clk_src <= SRC_INTERNAL;
    tt_mode    <= 1'b0;
    loopback   <= 1'b1;
    repeat (48) @(posedge ref_clk);
    n = 0;
    st_prev = 1'b1;
    for (i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      #1;
      if (st_pin === 1'b1 && st_prev === 1'b0) begin
        n++;
        check("rd_rt_pin", {6'h0, sd_pin, 1'b1}, {6'h0, rd_pin, rt_pin});
      end
      st_prev = st_pin;
    end
    check("loop_edges", 8'h01, {7'h0, n > 4});
    print_verdict();
  end
endmodule
`default_nettype wire
